// *** cms_map.svh ***
// register map, field positions, reset values and notes for the counter sequencer
//
// Notes on behaviour
// - mode comes from gate-control bits 15..13 and count-behaviour bits 7..5 only.
// - only active-going source and gate transitions count as edges.
// - stop or disarm at terminal count waits for the edge leaving terminal count.
// - level-gated strobe counts source edges only while the gate is active.
// - level-gated strobe reloads from load and disarms at terminal count.
// - edge-triggered strobe waits for a gate edge; edges while disarmed are ignored.
// - edge strobe counts from the first source edge after trigger, reloads, disarms.
// - after the trigger edge the gate is ignored for the rest of the cycle.
// - ungated rate generator repeats, reloads from load, ignores the gate.
// - toggle output of a rate generator gives a square wave set by load.
// - level-gated rate generator repeats but counts only while the gate is active.
// - one-shot starts on gate edge, reloads from load, stays armed awaiting gate.
// - one-shot ignores the gate from its trigger edge until terminal count.
// - ungated delayed pulse ignores gate, reaches terminal count twice, then disarms.
// - delayed pulse reloads from hold first, then from load and disarms.
// - start value comes from a load command or an earlier terminal-count reload.
// - delayed pulse toggle output: start value sets delay, hold sets width.
// - gated delayed pulse counts only while gate is active, stretching both phases.
// - triggered delayed pulse starts after a gate edge on an armed counter.
// - triggered delayed pulse ignores gate until second terminal count, then disarms.
// - variable duty mode runs until disarmed; odd reloads hold, even reloads load.
// - variable duty toggle output: load and hold set the two output portions.
`ifndef CMS_MAP_SVH
`define CMS_MAP_SVH

// ----------------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------------
`define CMS_OFF_MODE 8'h00
`define CMS_OFF_LOAD 8'h04
`define CMS_OFF_HOLD 8'h08
`define CMS_OFF_CMD 8'h0C
`define CMS_OFF_STAT 8'h10

// ----------------------------------------------------------------------
// mode fields and encodings
// ----------------------------------------------------------------------
`define CMS_GC_MSB 15
`define CMS_GC_LSB 13
`define CMS_CB_MSB 7
`define CMS_CB_LSB 5
`define CMS_GC_NONE 3'h0
`define CMS_GC_EDGE_TOP 2'h3
`define CMS_CB_STROBE 3'h0
`define CMS_CB_RATE 3'h1
`define CMS_CB_DELAY 3'h2
`define CMS_CB_VDC 3'h3

// ----------------------------------------------------------------------
// command and status bits, reset values
// ----------------------------------------------------------------------
`define CMS_CMD_ARM 0
`define CMS_CMD_DISARM 1
`define CMS_CMD_LOAD 2
`define CMS_ST_TC 0
`define CMS_ST_TOGGLE 1
`define CMS_ST_ARMED 2
`define CMS_ST_WAIT 3
`define CMS_ST_CNT_LSB 16
`define CMS_MODE_RST 16'h0000
`define CMS_LOAD_RST 16'h0000
`define CMS_HOLD_RST 16'h0000

`endif

// *** cms_pkg.sv ***
// types shared by the counter mode sequencer
package cms_pkg;

    // counter phase: disarmed, armed awaiting gate, counting, in terminal count
    typedef enum logic [1:0] {
        PH_IDLE,
        PH_WAIT,
        PH_RUN,
        PH_TC
    } cms_phase_t;

    // what leaving terminal count does next
    typedef enum logic [1:0] {
        END_GO,
        END_WAIT,
        END_DISARM
    } cms_end_t;

    // whole state of the sequencer
    typedef struct packed {
        logic [2:0] src_sync;
        logic [2:0] gate_sync;
        logic [15:0] mode;
        logic [15:0] load;
        logic [15:0] hold;
        logic [15:0] count;
        cms_phase_t phase;
        cms_end_t end_act;
        logic second;
        logic use_hold;
        logic toggle;
        logic tc_out;
        logic ahb_wr;
        logic [7:0] ahb_addr;
        logic [31:0] hrdata;
        logic hready;
        logic hresp;
    } cms_state_t;

endpackage : cms_pkg

// *** cms_sequencer.sv ***
// counter mode sequencer with ahb-lite register slave
//
// The implementer's own choices: the register offsets and the AHB-Lite register port.
`include "cms_map.svh"
`timescale 1ns/100ps
`default_nettype none

module cms_sequencer (
    // clock and reset
    input wire logic clk_sys,
    input wire logic rst_n,
    // ahb-lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    // external count source and gate, active high
    input wire logic src_in,
    input wire logic gate_in,
    // counter outputs
    output logic tc_out,
    output logic toggle_out,
    output logic armed_out
);

    // ------------------------------------------------------------------
    // state registers
    // ------------------------------------------------------------------
    cms_pkg::cms_state_t st_q;
    cms_pkg::cms_state_t st_d;

    // ------------------------------------------------------------------
    // input decode
    // ------------------------------------------------------------------
    logic src_edge;
    logic gate_edge;
    logic gate_lvl;
    logic [2:0] gc;
    logic [2:0] cb;
    logic gate_none;
    logic edge_md;
    logic level_md;
    logic known_md;
    logic qualified;
    logic twice;
    logic addr_sel;
    logic [31:0] rd_mux;
    logic [31:0] status_word;

    // edges use the second and third stages only
    assign src_edge = st_q.src_sync[1] & ~st_q.src_sync[2];
    assign gate_edge = st_q.gate_sync[1] & ~st_q.gate_sync[2];
    assign gate_lvl = st_q.gate_sync[1];

    // mode selection ignores bits 12..8
    assign gc = st_q.mode[`CMS_GC_MSB:`CMS_GC_LSB];
    assign cb = st_q.mode[`CMS_CB_MSB:`CMS_CB_LSB];

    // gate handling class of the mode
    assign gate_none = (gc == `CMS_GC_NONE);
    assign edge_md = (gc[2:1] == `CMS_GC_EDGE_TOP);
    assign level_md = ~gate_none & ~edge_md;

    // retriggering modes are outside this block and never count
    assign known_md = ~cb[2];

    // level modes only count edges seen with the gate active
    assign qualified = src_edge & known_md & (~level_md | gate_lvl);

    // delayed pulse and variable duty alternate hold and load
    assign twice = (cb == `CMS_CB_DELAY) || (cb == `CMS_CB_VDC);

    // ------------------------------------------------------------------
    // read path
    // ------------------------------------------------------------------
    // status is sampled one cycle late; adequate for software polling
    always_comb begin
        status_word = 32'h0000_0000;
        status_word[31:`CMS_ST_CNT_LSB] = st_q.count;
        status_word[`CMS_ST_TC] = st_q.tc_out;
        status_word[`CMS_ST_TOGGLE] = st_q.toggle;
        status_word[`CMS_ST_ARMED] = (st_q.phase != cms_pkg::PH_IDLE);
        status_word[`CMS_ST_WAIT] = (st_q.phase == cms_pkg::PH_WAIT);
    end

    // address decode; unmapped reads return zero
    always_comb begin
        case (haddr[7:0])
            `CMS_OFF_MODE: begin
                rd_mux = {16'h0000, st_q.mode};
            end
            `CMS_OFF_LOAD: begin
                rd_mux = {16'h0000, st_q.load};
            end
            `CMS_OFF_HOLD: begin
                rd_mux = {16'h0000, st_q.hold};
            end
            `CMS_OFF_STAT: begin
                rd_mux = status_word;
            end
            default: begin
                rd_mux = 32'h0000_0000;
            end
        endcase
    end

    // a transfer is taken only when selected, active and bus ready
    assign addr_sel = hsel & hready & htrans[1];

    // ------------------------------------------------------------------
    // next state
    // ------------------------------------------------------------------
    always_comb begin
        st_d = st_q;

        // two-stage synchronisers plus an edge history stage
        st_d.src_sync = {st_q.src_sync[1:0], src_in};
        st_d.gate_sync = {st_q.gate_sync[1:0], gate_in};

        // counter sequencing
        case (st_q.phase)
            cms_pkg::PH_IDLE: begin
                // disarmed: gate edges are dropped here
                st_d.phase = cms_pkg::PH_IDLE;
            end
            cms_pkg::PH_WAIT: begin
                // source edges in this cycle do not count yet
                if (gate_edge) begin
                    st_d.phase = cms_pkg::PH_RUN;
                end
            end
            cms_pkg::PH_RUN: begin
                // gate no longer read in edge modes while running
                if (qualified) begin
                    if (st_q.count == 16'h0001) begin
                        st_d.count = 16'h0000;
                        st_d.phase = cms_pkg::PH_TC;
                        st_d.toggle = ~st_q.toggle;
                        st_d.use_hold = twice & ~st_q.second;
                        st_d.second = twice & ~st_q.second;
                        case (cb)
                            `CMS_CB_STROBE: begin
                                st_d.end_act = cms_pkg::END_DISARM;
                            end
                            `CMS_CB_RATE: begin
                                if (edge_md) begin
                                    st_d.end_act = cms_pkg::END_WAIT;
                                end else begin
                                    st_d.end_act = cms_pkg::END_GO;
                                end
                            end
                            `CMS_CB_DELAY: begin
                                if (st_q.second) begin
                                    st_d.end_act = cms_pkg::END_DISARM;
                                end else begin
                                    st_d.end_act = cms_pkg::END_GO;
                                end
                            end
                            default: begin
                                if (edge_md && st_q.second) begin
                                    st_d.end_act = cms_pkg::END_WAIT;
                                end else begin
                                    st_d.end_act = cms_pkg::END_GO;
                                end
                            end
                        endcase
                    end else begin
                        st_d.count = st_q.count - 16'h0001;
                    end
                end
            end
            cms_pkg::PH_TC: begin
                // terminal count always counts out, then the stop applies
                if (src_edge) begin
                    if (st_q.use_hold) begin
                        st_d.count = st_q.hold;
                    end else begin
                        st_d.count = st_q.load;
                    end
                    case (st_q.end_act)
                        cms_pkg::END_GO: begin
                            st_d.phase = cms_pkg::PH_RUN;
                        end
                        cms_pkg::END_WAIT: begin
                            st_d.phase = cms_pkg::PH_WAIT;
                        end
                        default: begin
                            st_d.phase = cms_pkg::PH_IDLE;
                        end
                    endcase
                end
            end
            default: begin
                st_d.phase = cms_pkg::PH_IDLE;
            end
        endcase

        // register writes land in the data phase
        if (st_q.ahb_wr) begin
            case (st_q.ahb_addr)
                `CMS_OFF_MODE: begin
                    st_d.mode = hwdata[15:0];
                end
                `CMS_OFF_LOAD: begin
                    st_d.load = hwdata[15:0];
                end
                `CMS_OFF_HOLD: begin
                    st_d.hold = hwdata[15:0];
                end
                `CMS_OFF_CMD: begin
                    // load is refused during terminal count to keep the reload intact
                    if (hwdata[`CMS_CMD_LOAD] && (st_d.phase != cms_pkg::PH_TC)) begin
                        st_d.count = st_q.load;
                    end
                    // disarm in terminal count is deferred until it ends
                    if (hwdata[`CMS_CMD_DISARM]) begin
                        if (st_d.phase == cms_pkg::PH_TC) begin
                            st_d.end_act = cms_pkg::END_DISARM;
                        end else begin
                            st_d.phase = cms_pkg::PH_IDLE;
                        end
                    end
                    // arm restarts alternation from hold
                    if (hwdata[`CMS_CMD_ARM] && (st_d.phase == cms_pkg::PH_IDLE)) begin
                        st_d.second = 1'b0;
                        if (edge_md) begin
                            st_d.phase = cms_pkg::PH_WAIT;
                        end else begin
                            st_d.phase = cms_pkg::PH_RUN;
                        end
                    end
                end
                default: begin
                    st_d.mode = st_q.mode;
                end
            endcase
        end

        // plain output pulses for the whole terminal count state
        st_d.tc_out = (st_d.phase == cms_pkg::PH_TC);

        // address phase capture; zero wait states always
        st_d.ahb_wr = addr_sel & hwrite;
        st_d.ahb_addr = haddr[7:0];
        if (addr_sel && !hwrite) begin
            st_d.hrdata = rd_mux;
        end else begin
            st_d.hrdata = 32'h0000_0000;
        end
        st_d.hready = 1'b1;
        st_d.hresp = 1'b0;
    end

    // ------------------------------------------------------------------
    // state flip-flops
    // ------------------------------------------------------------------
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            st_q.src_sync <= 3'h0;
            st_q.gate_sync <= 3'h0;
            st_q.mode <= `CMS_MODE_RST;
            st_q.load <= `CMS_LOAD_RST;
            st_q.hold <= `CMS_HOLD_RST;
            st_q.count <= 16'h0000;
            st_q.phase <= cms_pkg::PH_IDLE;
            st_q.end_act <= cms_pkg::END_GO;
            st_q.second <= 1'b0;
            st_q.use_hold <= 1'b0;
            st_q.toggle <= 1'b0;
            st_q.tc_out <= 1'b0;
            st_q.ahb_wr <= 1'b0;
            st_q.ahb_addr <= 8'h00;
            st_q.hrdata <= 32'h0000_0000;
            st_q.hready <= 1'b1;
            st_q.hresp <= 1'b0;
        end else begin
            st_q <= st_d;
        end
    end

    // ------------------------------------------------------------------
    // outputs, all straight from state
    // ------------------------------------------------------------------
    assign hrdata = st_q.hrdata;
    assign hreadyout = st_q.hready;
    assign hresp = st_q.hresp;
    assign tc_out = st_q.tc_out;
    assign toggle_out = st_q.toggle;
    assign armed_out = (st_q.phase != cms_pkg::PH_IDLE);

endmodule : cms_sequencer

`default_nettype wire

// *** cms_ext.sv ***
// partner model: external count source and gate pins
`timescale 1ns/100ps
`default_nettype none

module cms_ext (
    // clock
    input wire logic clk_sys,
    // source and gate pins, active high
    output logic src_in,
    output logic gate_in
);
    // both pins idle low and are always driven
    initial begin
        src_in = 1'h0;
        gate_in = 1'h0;
    end

    // each high held 3 clocks, each low at least 3, so the two-stage sync never misses it
    task src(input int n);
        repeat (n) begin
            @(posedge clk_sys) src_in <= 1'h1;
            repeat (3) @(posedge clk_sys);
            src_in <= 1'h0;
            repeat (3) @(posedge clk_sys);
        end
        repeat (3) @(posedge clk_sys);
    endtask : src

    // callers arm before any triggering rise
    task gate(input logic v);
        @(posedge clk_sys) gate_in <= v;
        repeat (6) @(posedge clk_sys);
    endtask : gate
endmodule : cms_ext
`default_nettype wire

// *** cms_sequencer_chk.sv ***
// port-level assertions for the counter mode sequencer
`timescale 1ns/100ps
`default_nettype none

module cms_sequencer_chk (
    // clock and reset
    input wire logic clk_sys,
    input wire logic rst_n,
    // ahb-lite
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    input wire logic [31:0] hrdata,
    input wire logic hreadyout,
    input wire logic hresp,
    // counter pins
    input wire logic src_in,
    input wire logic gate_in,
    input wire logic tc_out,
    input wire logic toggle_out,
    input wire logic armed_out
);
    logic src_q;
    logic cmd_q;
    logic rd_q;
    logic [7:0] since_src;
    logic [7:0] since_cmd;

    // saturating ages of the last source rise and command write
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            src_q <= 1'h0;
            cmd_q <= 1'h0;
            rd_q <= 1'h0;
            since_src <= 8'hFF;
            since_cmd <= 8'hFF;
        end else begin
            src_q <= src_in;
            cmd_q <= hsel && hready && htrans[1] && hwrite && (haddr[7:0] == 8'h0C);
            rd_q <= hsel && hready && htrans[1] && !hwrite;
            since_src <= (src_in && !src_q) ? 8'h00 : since_src + {7'h00, since_src != 8'hFF};
            since_cmd <= cmd_q ? 8'h00 : since_cmd + {7'h00, since_cmd != 8'hFF};
        end
    end

    default clocking @(posedge clk_sys); endclocking
    default disable iff (!rst_n);

    property p_bus_ok;
        hreadyout && !hresp;
    endproperty
    a_bus_ok: assert property (p_bus_ok) else $error("bus not ready or not okay");

    property p_rdata_idle;
        !rd_q |-> hrdata == 32'h0;
    endproperty
    a_rdata_idle: assert property (p_rdata_idle) else $error("read data outside data phase");

    property p_tog_on_tc;
        $rose(tc_out) |-> $changed(toggle_out);
    endproperty
    a_tog_on_tc: assert property (p_tog_on_tc) else $error("toggle did not flip");

    property p_tog_only_tc;
        $changed(toggle_out) |-> $rose(tc_out);
    endproperty
    a_tog_only_tc: assert property (p_tog_only_tc) else $error("toggle flip without tc");

    property p_tc_armed;
        tc_out |-> armed_out;
    endproperty
    a_tc_armed: assert property (p_tc_armed) else $error("tc while disarmed");

    property p_tc_hold;
        $rose(tc_out) |=> tc_out [*3];
    endproperty
    a_tc_hold: assert property (p_tc_hold) else $error("tc left without source edge");

    property p_tc_src;
        ($rose(tc_out) || $fell(tc_out)) |-> since_src < 8'd12;
    endproperty
    a_tc_src: assert property (p_tc_src) else $error("tc moved with no source rise");

    property p_arm_cmd;
        $rose(armed_out) |-> since_cmd < 8'd4;
    endproperty
    a_arm_cmd: assert property (p_arm_cmd) else $error("armed without a command");
endmodule : cms_sequencer_chk

bind cms_sequencer cms_sequencer_chk u_chk (
    .clk_sys(clk_sys), .rst_n(rst_n), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .src_in(src_in), .gate_in(gate_in),
    .tc_out(tc_out), .toggle_out(toggle_out), .armed_out(armed_out)
);
`default_nettype wire

// *** tb_top.sv ***
// self-checking testbench for the counter mode sequencer
`include "cms_map.svh"
`timescale 1ns/100ps
`default_nettype none

module tb_top;
    // ------------------------------------------------------------------
    // signals
    // ------------------------------------------------------------------
    logic clk_sys = 1'h0;
    logic rst_n = 1'h0;
    logic hsel = 1'h0;
    logic hwrite = 1'h0;
    logic [1:0] htrans = 2'h0;
    logic [2:0] hsize = 3'h0;
    logic [31:0] haddr = 32'h0;
    logic [31:0] hwdata = 32'h0;
    logic [31:0] hrdata;
    logic [31:0] rd;
    logic hreadyout;
    logic hresp;
    logic src_in;
    logic gate_in;
    logic tc_out;
    logic toggle_out;
    logic armed_out;
    int failures = 0;
    int n_checks = 0;

    // 20 mhz clock
    always #25 clk_sys = ~clk_sys;

    cms_sequencer dut (
        .clk_sys(clk_sys), .rst_n(rst_n), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(hresp), .src_in(src_in), .gate_in(gate_in),
        .tc_out(tc_out), .toggle_out(toggle_out), .armed_out(armed_out)
    );
    cms_ext u_ext (.clk_sys(clk_sys), .src_in(src_in), .gate_in(gate_in));

    // ------------------------------------------------------------------
    // shared tasks
    // ------------------------------------------------------------------
    task end_of_test;
        $display("checks %0d failures %0d", n_checks, failures);
        if (failures == 0 && n_checks > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask : end_of_test

    task chk(input logic [31:0] s, input logic [31:0] e);
        n_checks++;
        if (s !== e) begin
            failures++;
            $display("ERROR %0t seen %h expected %h", $time, s, e);
        end
    endtask : chk

    // bounded wait for hready; a hung bus ends the run
    task wt;
        int i;
        i = 0;
        @(posedge clk_sys);
        while (hreadyout !== 1'h1 && i < 20) begin
            i++;
            @(posedge clk_sys);
        end
        if (hreadyout !== 1'h1) begin
            failures++;
            end_of_test;
        end
    endtask : wt

    // one single word transfer; read data taken at the data phase edge
    task xf(input logic w, input logic [7:0] a, input logic [31:0] d);
        hsel <= 1'h1;
        haddr <= {24'h0, a};
        hwrite <= w;
        hsize <= 3'h2;
        htrans <= 2'h2;
        wt;
        hsel <= 1'h0;
        htrans <= 2'h0;
        hwdata <= d;
        wt;
        rd = hrdata;
    endtask : xf

    // gate low, 4-cycle reset, then mode, load, hold and command
    task cfg(input logic [15:0] m, input logic [15:0] l, input logic [15:0] h,
             input logic [2:0] c);
        u_ext.gate(1'h0);
        rst_n <= 1'h0;
        repeat (4) @(posedge clk_sys);
        rst_n <= 1'h1;
        @(posedge clk_sys);
        xf(1'h1, `CMS_OFF_MODE, {16'h0, m});
        xf(1'h1, `CMS_OFF_LOAD, {16'h0, l});
        xf(1'h1, `CMS_OFF_HOLD, {16'h0, h});
        xf(1'h1, `CMS_OFF_CMD, {29'h0, c});
    endtask : cfg

    // n source pulses, then status {count, wait, armed, toggle, tc}
    task sc(input int n, input logic [15:0] c, input logic [3:0] b);
        u_ext.src(n);
        xf(1'h0, `CMS_OFF_STAT, 32'h0);
        chk(rd, {c, 12'h000, b});
        // pins must agree with the status just read; no source edge since
        chk({29'h0, armed_out, toggle_out, tc_out}, {29'h0, b[2:0]});
    endtask : sc

    // ------------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------------
    task t_regs;
        cfg(16'h0, 16'h0, 16'h0, 3'h0);
        sc(0, 16'h0, 4'h0);
        xf(1'h1, `CMS_OFF_MODE, 32'hFFFF_FFFF);
        xf(1'h0, `CMS_OFF_MODE, 32'h0);
        chk(rd, 32'h0000_FFFF);
        xf(1'h1, 8'h14, 32'h1234_5678);
        xf(1'h0, 8'h14, 32'h0);
        chk(rd, 32'h0);
        $display("registers done");
    endtask : t_regs

    // filler bits set around the mode fields must not matter
    task t_rate;
        cfg(16'h1F3F, 16'h3, 16'h0, 3'h5);
        u_ext.gate(1'h1);
        sc(2, 16'h1, 4'h4);
        sc(1, 16'h0, 4'h7);
        sc(1, 16'h3, 4'h6);
        sc(3, 16'h0, 4'h5);
        sc(1, 16'h3, 4'h4);
        $display("rate generator done");
    endtask : t_rate

    task t_level;
        cfg(16'h2000, 16'h2, 16'h0, 3'h5);
        sc(2, 16'h2, 4'h4);
        u_ext.gate(1'h1);
        sc(2, 16'h0, 4'h7);
        u_ext.gate(1'h0);
        sc(1, 16'h2, 4'h2);
        sc(2, 16'h2, 4'h2);
        cfg(16'h2020, 16'h2, 16'h0, 3'h5);
        sc(1, 16'h2, 4'h4);
        u_ext.gate(1'h1);
        sc(2, 16'h0, 4'h7);
        sc(1, 16'h2, 4'h6);
        $display("level gated done");
    endtask : t_level

    task t_edge;
        cfg(16'hC000, 16'h2, 16'h0, 3'h4);
        u_ext.gate(1'h1);
        u_ext.gate(1'h0);
        xf(1'h1, `CMS_OFF_CMD, 32'h1);
        sc(2, 16'h2, 4'hC);
        u_ext.gate(1'h1);
        sc(1, 16'h1, 4'h4);
        u_ext.gate(1'h0);
        u_ext.gate(1'h1);
        sc(1, 16'h0, 4'h7);
        sc(1, 16'h2, 4'h2);
        cfg(16'hC020, 16'h2, 16'h0, 3'h5);
        sc(1, 16'h2, 4'hC);
        u_ext.gate(1'h1);
        sc(1, 16'h1, 4'h4);
        u_ext.gate(1'h0);
        u_ext.gate(1'h1);
        sc(1, 16'h0, 4'h7);
        sc(2, 16'h2, 4'hE);
        u_ext.gate(1'h0);
        u_ext.gate(1'h1);
        sc(2, 16'h0, 4'h5);
        $display("edge triggered done");
    endtask : t_edge

    task t_delay;
        cfg(16'h0040, 16'h2, 16'h3, 3'h5);
        u_ext.gate(1'h1);
        sc(2, 16'h0, 4'h7);
        sc(1, 16'h3, 4'h6);
        sc(3, 16'h0, 4'h5);
        sc(2, 16'h2, 4'h0);
        cfg(16'h2040, 16'h1, 16'h1, 3'h5);
        sc(1, 16'h1, 4'h4);
        u_ext.gate(1'h1);
        sc(2, 16'h1, 4'h6);
        u_ext.gate(1'h0);
        sc(1, 16'h1, 4'h6);
        u_ext.gate(1'h1);
        sc(2, 16'h1, 4'h0);
        cfg(16'hC040, 16'h1, 16'h1, 3'h5);
        sc(1, 16'h1, 4'hC);
        u_ext.gate(1'h1);
        sc(1, 16'h0, 4'h7);
        u_ext.gate(1'h0);
        sc(2, 16'h0, 4'h5);
        sc(1, 16'h1, 4'h0);
        u_ext.gate(1'h1);
        sc(1, 16'h1, 4'h0);
        xf(1'h1, `CMS_OFF_CMD, 32'h1);
        sc(1, 16'h1, 4'hC);
        $display("delayed pulse done");
    endtask : t_delay

    // disarm issued inside tc must wait for the edge leaving it
    task t_vdc;
        cfg(16'h0060, 16'h1, 16'h2, 3'h5);
        sc(1, 16'h0, 4'h7);
        sc(1, 16'h2, 4'h6);
        sc(2, 16'h0, 4'h5);
        sc(1, 16'h1, 4'h4);
        sc(1, 16'h0, 4'h7);
        xf(1'h1, `CMS_OFF_CMD, 32'h2);
        sc(0, 16'h0, 4'h7);
        sc(1, 16'h2, 4'h2);
        sc(1, 16'h2, 4'h2);
        $display("variable duty done");
    endtask : t_vdc

    // ------------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------------
    initial begin
        t_regs;
        t_rate;
        t_level;
        t_edge;
        t_delay;
        t_vdc;
        end_of_test;
    end
endmodule : tb_top
`default_nettype wire
